// ==== csp_pkg.sv ====
// Package for the clock security and PLL select block
package csp_pkg;
    localparam int CSP_AW = 4;
    localparam logic [3:0] CSP_ADDR_PAGE1 = 4'h0;
    localparam logic [3:0] CSP_ADDR_PAGE0 = 4'h1;
    localparam logic [7:0] CSP_PAGE1_RST = 8'h00;
    localparam logic [7:0] CSP_PAGE0_RST = 8'h00;
    // Page 1 bit positions
    localparam int CSP_BIT_PAGE = 7;
    localparam int CSP_BIT_VCO = 5;
    localparam int CSP_BIT_LOCK = 4;
    localparam int CSP_BIT_PLL_ENABLE_BIT = 3;
    localparam int CSP_BIT_CLOCK_SOURCE_SELECT = 1;
    // Page 0 bit positions
    localparam int CSP_BIT_LOSS_IE = 2;
    localparam int CSP_BIT_LOSS_F = 3;
    localparam int CSP_BIT_VD_IE = 5;
    localparam int CSP_BIT_VD_F = 6;
    // Rates in MHz
    localparam int CSP_FIN_MHZ = 8;
    localparam int CSP_FOUT_MHZ = 16;
    localparam int CSP_FVCO_GND_MHZ = 10;
    // Timing
    localparam int CSP_LOCK_TIME_US = 2;
    localparam int CSP_CLK_MHZ = 50;
    localparam int CSP_LOCK_CYCLES = CSP_LOCK_TIME_US * CSP_CLK_MHZ;
    localparam int CSP_LOSS_TIME_NS = 500;
    localparam int CSP_LOSS_CYCLES = (CSP_LOSS_TIME_NS * CSP_CLK_MHZ) / 1000;
    localparam int CSP_CW = 8;
    typedef enum logic [1:0] {
        CSP_RUN,
        CSP_HALT,
        CSP_AHALT
    } csp_mode_t;
endpackage

// ==== csp_clock_security.sv ====
// Clock security, PLL control and clock source selection
`timescale 1ns/1ns
`default_nettype none
module csp_clock_security
    import csp_pkg::*;
(
    input wire logic clk,                        // System clock, 50 MHz
    input wire logic srst,                       // Synchronous reset
    input wire logic [csp_pkg::CSP_AW-1:0] addr, // Register address
    input wire logic [7:0] wdata,                // Write data
    input wire logic wr,                         // Write strobe
    input wire logic rd,                         // Read strobe
    output logic [7:0] rdata,                    // Read data, cycle after rd
    input wire logic osc_clk_pin,                // Oscillator clock, sampled
    input wire logic pll_opt_en,                 // Option: PLL enabled
    input wire logic pll_opt_sel,                // Option: PLL fixed as source
    input wire logic icc_active,                 // In-circuit programming
    input wire logic voltage_drop_pin,           // Voltage-drop detector event
    input wire logic global_int_mask,            // Processor interrupt mask
    input wire logic wait_mode,                  // Processor in wait
    input wire logic halt_req,                   // Processor enters halt
    input wire logic active_halt_req,            // Processor enters active-halt
    output logic [1:0] halt_state,               // 0 run, 1 halt, 2 active-halt
    output logic pll_lock,                       // PLL locked
    output logic [4:0] pll_out_mhz,              // Produced PLL frequency
    output logic sysclk_is_pll,                  // System clock from PLL
    output logic safe_clock_on,                  // Safe oscillator running
    output logic hold_reset,                     // Keep device in reset
    output logic clock_loss_irq,                 // Clock loss interrupt request
    output logic voltage_drop_irq,               // Voltage drop interrupt request
    output logic wake_req                        // Wake from wait or halt
);
    import csp_pkg::*;

    logic osc_s1_q, osc_s2_q, osc_s3_q;
    logic vd_s1_q, vd_s2_q;
    logic page_q, vco_q, pll_enable_bit_q, clock_source_select_q;
    logic loss_ie_q, loss_f_q, vd_ie_q, vd_f_q;
    logic lock_q, osc_seen_q, lost_q, icc_q;
    logic [CSP_CW-1:0] lock_cnt_q, loss_cnt_q;
    logic [7:0] rdata_q;
    csp_mode_t mode_q;
    logic pll_on, frozen, wr_p1, wr_p0, osc_edge, loss_evt, icc_rise;

    function automatic logic [7:0] page1_view(input logic pg, input logic v, input logic lk,
                                              input logic en, input logic sel);
        page1_view = 8'h00;
        page1_view[CSP_BIT_PAGE] = pg;
        page1_view[CSP_BIT_VCO] = v;
        page1_view[CSP_BIT_LOCK] = lk;
        page1_view[CSP_BIT_PLL_ENABLE_BIT] = en;
        page1_view[CSP_BIT_CLOCK_SOURCE_SELECT] = sel;
    endfunction

    // Pin inputs pass two flops before use
    always_ff @(posedge clk) begin
        osc_s1_q <= osc_clk_pin;
        osc_s2_q <= osc_s1_q;
        osc_s3_q <= osc_s2_q;
        vd_s1_q <= voltage_drop_pin;
        vd_s2_q <= vd_s1_q;
    end

    assign osc_edge = osc_s2_q ^ osc_s3_q;
    assign frozen = (mode_q != CSP_RUN);
    assign pll_on = (pll_enable_bit_q | pll_opt_en) & (mode_q != CSP_HALT);
    assign wr_p1 = wr & (addr == CSP_ADDR_PAGE1) & page_q & ~frozen;
    // Page 0 is reached at its own address, or at the shared one while the page bit is 0
    assign wr_p0 = wr & ~frozen & ((addr == CSP_ADDR_PAGE0) | ((addr == CSP_ADDR_PAGE1) & ~page_q));
    assign icc_rise = icc_active & ~icc_q;

    // Processor power mode; halt ends only by wake or reset
    always_ff @(posedge clk) begin
        if (srst) begin
            mode_q <= CSP_RUN;
        end else begin
            unique case (mode_q)
                CSP_RUN: begin
                    if (halt_req) begin
                        mode_q <= CSP_HALT;
                    end else if (active_halt_req) begin
                        mode_q <= CSP_AHALT;
                    end
                end
                CSP_HALT, CSP_AHALT: begin
                    if (wake_req) begin
                        mode_q <= CSP_RUN;
                    end
                end
                default: mode_q <= CSP_RUN;
            endcase
        end
    end

    // Oscillator watch: missing edges mean a lost input clock
    always_ff @(posedge clk) begin
        if (srst) begin
            loss_cnt_q <= '0;
            osc_seen_q <= 1'b0;
            lost_q <= 1'b0;
        end else begin
            if (osc_edge) begin
                loss_cnt_q <= '0;
                osc_seen_q <= 1'b1;
                lost_q <= 1'b0;
            end else if (loss_cnt_q != CSP_CW'(CSP_LOSS_CYCLES)) begin
                loss_cnt_q <= loss_cnt_q + 1'b1;
            end else if (osc_seen_q & pll_on) begin
                lost_q <= 1'b1;
            end
        end
    end

    // Without edges since reset the device stays in reset
    assign hold_reset = ~osc_seen_q;
    assign loss_evt = osc_seen_q & pll_on & ~lost_q & ~osc_edge
                      & (loss_cnt_q == CSP_CW'(CSP_LOSS_CYCLES));

    // Lock timer restarts whenever the PLL is off or the input is lost
    always_ff @(posedge clk) begin
        if (srst) begin
            lock_cnt_q <= '0;
            lock_q <= 1'b0;
        end else if (!pll_on || lost_q) begin
            lock_cnt_q <= '0;
            lock_q <= 1'b0;
        end else if (lock_cnt_q != CSP_CW'(CSP_LOCK_CYCLES)) begin
            lock_cnt_q <= lock_cnt_q + 1'b1;
        end else begin
            lock_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            icc_q <= 1'b0;
        end else begin
            icc_q <= icc_active;
        end
    end

    // Page 1 control bits; writes frozen while halted, a programming entry still sets the VCO, enable and select bits but not the page bit
    always_ff @(posedge clk) begin
        if (srst) begin
            page_q <= CSP_PAGE1_RST[CSP_BIT_PAGE];
            vco_q <= CSP_PAGE1_RST[CSP_BIT_VCO];
            pll_enable_bit_q <= CSP_PAGE1_RST[CSP_BIT_PLL_ENABLE_BIT];
            clock_source_select_q <= CSP_PAGE1_RST[CSP_BIT_CLOCK_SOURCE_SELECT];
        end else if (icc_rise) begin
            vco_q <= 1'b1;
            pll_enable_bit_q <= 1'b1;
            clock_source_select_q <= 1'b1;
        end else begin
            if (wr && !frozen && (addr == CSP_ADDR_PAGE1 || addr == CSP_ADDR_PAGE0)) begin
                page_q <= wdata[CSP_BIT_PAGE];
            end
            if (wr_p1) begin
                vco_q <= wdata[CSP_BIT_VCO];
                // Reserved bits 6, 2, 0 are not stored
                if (wdata[CSP_BIT_PLL_ENABLE_BIT] || !clock_source_select_q) begin
                    pll_enable_bit_q <= wdata[CSP_BIT_PLL_ENABLE_BIT];
                end
                clock_source_select_q <= wdata[CSP_BIT_CLOCK_SOURCE_SELECT] & (pll_enable_bit_q | wdata[CSP_BIT_PLL_ENABLE_BIT]);
            end
        end
    end

    // Page 0: interrupt enables and sticky flags; set beats clear
    always_ff @(posedge clk) begin
        if (srst) begin
            loss_ie_q <= CSP_PAGE0_RST[CSP_BIT_LOSS_IE];
            vd_ie_q <= CSP_PAGE0_RST[CSP_BIT_VD_IE];
            loss_f_q <= CSP_PAGE0_RST[CSP_BIT_LOSS_F];
            vd_f_q <= CSP_PAGE0_RST[CSP_BIT_VD_F];
        end else begin
            if (wr_p0) begin
                loss_ie_q <= wdata[CSP_BIT_LOSS_IE];
                vd_ie_q <= wdata[CSP_BIT_VD_IE];
            end
            if (loss_evt) begin
                loss_f_q <= 1'b1;
            end else if (wr_p0 && !wdata[CSP_BIT_LOSS_F]) begin
                loss_f_q <= 1'b0;
            end
            if (vd_s2_q) begin
                vd_f_q <= 1'b1;
            end else if (wr_p0 && !wdata[CSP_BIT_VD_F]) begin
                vd_f_q <= 1'b0;
            end
        end
    end

    // Read data one cycle after the strobe, else zero
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= 8'h00;
        end else if (rd && addr == CSP_ADDR_PAGE1 && page_q) begin
            rdata_q <= page1_view(page_q, vco_q, lock_q, pll_enable_bit_q | pll_opt_en, sysclk_is_pll);
        end else if (rd && (addr == CSP_ADDR_PAGE0 || addr == CSP_ADDR_PAGE1)) begin
            rdata_q <= {page_q, vd_f_q, vd_ie_q, 1'b0, loss_f_q, loss_ie_q, 2'b00};
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign rdata = rdata_q;

    // Lock drops at once when the PLL is switched off, not a cycle later
    assign pll_lock = lock_q & pll_on;
    assign halt_state = mode_q;
    assign safe_clock_on = lost_q & pll_on;
    // Option fixes the source regardless of the select bit
    assign sysclk_is_pll = pll_on & (pll_opt_sel | clock_source_select_q | lost_q);
    assign pll_out_mhz = !pll_on ? 5'h00 :
                         (vco_q | lost_q) ? 5'(CSP_FVCO_GND_MHZ) : 5'(CSP_FOUT_MHZ);
    assign clock_loss_irq = loss_f_q & loss_ie_q & ~global_int_mask;
    assign voltage_drop_irq = vd_f_q & vd_ie_q & ~global_int_mask;
    // Full halt stops the clock watch so only voltage drop can wake it
    assign wake_req = voltage_drop_irq
                      | (clock_loss_irq & (wait_mode | mode_q == CSP_AHALT));
endmodule
`default_nettype wire

// ==== csp_clock_security_assertions.sv ====
// Concurrent checks on the clock security block ports
`timescale 1ns/1ns
`default_nettype none
module csp_clock_security_chk (
    input wire logic clk, // Clock
    input wire logic srst, // Reset
    input wire logic rd, // Read strobe
    input wire logic [7:0] rdata, // Read data
    input wire logic global_int_mask, // Irq mask
    input wire logic wait_mode, // Wait
    input wire logic [1:0] halt_state, // Halt state
    input wire logic pll_lock, // Lock
    input wire logic [4:0] pll_out_mhz, // PLL rate
    input wire logic sysclk_is_pll, // PLL source
    input wire logic safe_clock_on, // Safe clock
    input wire logic hold_reset, // Reset hold
    input wire logic clock_loss_irq, // Loss irq
    input wire logic voltage_drop_irq, // Drop irq
    input wire logic wake_req // Wake
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    property p_rate; pll_out_mhz == 5'h00 || pll_out_mhz == 5'h10 || pll_out_mhz == 5'h0a; endproperty
    a_rate: assert property (p_rate) else $error("pll rate not 0, 16 or 10");
    property p_hold; $fell(srst) |-> hold_reset; endproperty
    a_hold: assert property (p_hold) else $error("reset hold missing");
    property p_mask; (clock_loss_irq || voltage_drop_irq) |-> !global_int_mask; endproperty
    a_mask: assert property (p_mask) else $error("irq while masked");
    property p_halt_safe; halt_state == 2'h1 |-> !safe_clock_on; endproperty
    a_halt_safe: assert property (p_halt_safe) else $error("safe clock in halt");
    property p_no_loss_wake; (halt_state == 2'h1 && !voltage_drop_irq) |-> !wake_req; endproperty
    a_no_loss_wake: assert property (p_no_loss_wake) else $error("halt woken without drop");
    property p_wait_wake; (wait_mode && (clock_loss_irq || voltage_drop_irq)) |-> wake_req; endproperty
    a_wait_wake: assert property (p_wait_wake) else $error("wait not woken");
    property p_src; sysclk_is_pll |-> pll_out_mhz != 5'h00; endproperty
    a_src: assert property (p_src) else $error("pll source while pll off");
    property p_lock; (pll_lock && halt_state == 2'h0) |-> pll_out_mhz != 5'h00; endproperty
    a_lock: assert property (p_lock) else $error("lock with pll off");
    property p_rdata; !$past(rd) |-> rdata == 8'h00; endproperty
    a_rdata: assert property (p_rdata) else $error("read data outside slot");
    c_loss: cover property (clock_loss_irq);
    c_halt_wake: cover property (wake_req && halt_state == 2'h1);
    c_lock: cover property (pll_lock);
endmodule
bind csp_clock_security csp_clock_security_chk csp_chk_i (.clk(clk), .srst(srst), .rd(rd), .rdata(rdata),
    .global_int_mask(global_int_mask), .wait_mode(wait_mode), .halt_state(halt_state), .pll_lock(pll_lock),
    .pll_out_mhz(pll_out_mhz), .sysclk_is_pll(sysclk_is_pll), .safe_clock_on(safe_clock_on),
    .hold_reset(hold_reset), .clock_loss_irq(clock_loss_irq), .voltage_drop_irq(voltage_drop_irq),
    .wake_req(wake_req));
`default_nettype wire

// ==== csp_osc_model.sv ====
// Behavioural external resonator feeding the oscillator pin
`timescale 1ns/1ns
`default_nettype none
module csp_osc_model (
    input wire logic clk, // Bench clock
    input wire logic run, // Resonator alive
    output logic osc // Oscillator level
);
    logic [2:0] cnt_q = 3'h0;
    // Near 8 MHz; a dead resonator simply stops toggling
    always @(posedge clk) begin
        if (run) begin
            cnt_q <= (cnt_q == 3'h5) ? 3'h0 : cnt_q + 3'h1;
        end
    end
    assign osc = (cnt_q > 3'h2);
endmodule
`default_nettype wire

// ==== tb_csp_clock_security.sv ====
// Testbench for the clock security block
`timescale 1ns/1ns
`default_nettype none
module tb_csp_clock_security;
    import csp_pkg::*;
    logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, run = 1'b0, vd = 1'b0, wt = 1'b0, hr = 1'b0;
    logic in_circuit_programming = 1'b0, msk = 1'b0, osel = 1'b0;
    logic [CSP_AW-1:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata;
    logic [1:0] halt_state;
    logic [4:0] pll_out_mhz;
    logic osc, pll_lock, sysclk_is_pll, safe_clock_on, hold_reset, clock_loss_irq, voltage_drop_irq, wake_req;
    int err_count = 0, num_checks = 0;
    always #10 clk = ~clk;
    csp_osc_model csp_osc_model_i (.clk(clk), .run(run), .osc(osc));
    csp_clock_security csp_clock_security_i (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .osc_clk_pin(osc), .pll_opt_en(1'b0), .pll_opt_sel(osel), .icc_active(in_circuit_programming),
        .voltage_drop_pin(vd), .global_int_mask(msk), .wait_mode(wt), .halt_req(hr), .active_halt_req(1'b0),
        .halt_state(halt_state), .pll_lock(pll_lock), .pll_out_mhz(pll_out_mhz), .sysclk_is_pll(sysclk_is_pll),
        .safe_clock_on(safe_clock_on), .hold_reset(hold_reset), .clock_loss_irq(clock_loss_irq),
        .voltage_drop_irq(voltage_drop_irq), .wake_req(wake_req));
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    // Bounded wait; a run-out is a mismatch and ends the run
    task automatic wait_hi(input int sel, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(posedge clk);
            #1;
            if ((sel == 0 && pll_lock === 1'b1) || (sel == 1 && clock_loss_irq === 1'b1) ||
                (sel == 2 && wake_req === 1'b1) || (sel == 3 && hold_reset === 1'b0)) return;
        end
        err_count++;
        $display("unexpected timeout at %0t signal %0h expected %0h", $time, sel, 1);
        close_out();
    endtask
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        repeat (30) @(posedge clk);
        chk(hold_reset, 1'b1);
        run <= 1'b1;
        wait_hi(3, 50);
        $display("test start done");
        wr_reg(CSP_ADDR_PAGE0, 8'h80);
        rd_chk(CSP_ADDR_PAGE1, 8'h80);
        wr_reg(CSP_ADDR_PAGE1, 8'h88);
        wr_reg(CSP_ADDR_PAGE1, 8'h8a);
        wait_hi(0, 200);
        rd_chk(CSP_ADDR_PAGE1, 8'h9a);
        chk(pll_out_mhz, 8'h10);
        chk(sysclk_is_pll, 1'b1);
        wr_reg(CSP_ADDR_PAGE1, 8'h82);
        rd_chk(CSP_ADDR_PAGE1, 8'h9a);
        wr_reg(CSP_ADDR_PAGE1, 8'h88);
        wr_reg(CSP_ADDR_PAGE1, 8'h80);
        wr_reg(CSP_ADDR_PAGE1, 8'h82);
        #1 chk(sysclk_is_pll, 1'b0);
        wr_reg(CSP_ADDR_PAGE1, 8'ha8);
        wait_hi(0, 200);
        chk(pll_out_mhz, 8'h0a);
        $display("test pll done");
        wr_reg(CSP_ADDR_PAGE0, 8'h24);
        wt <= 1'b1;
        run <= 1'b0;
        wait_hi(1, 100);
        chk(wake_req, 1'b1);
        chk(safe_clock_on, 1'b1);
        rd_chk(CSP_ADDR_PAGE0, 8'h2c);
        run <= 1'b1;
        wt <= 1'b0;
        repeat (20) @(posedge clk);
        rd_chk(CSP_ADDR_PAGE0, 8'h2c);
        wr_reg(CSP_ADDR_PAGE0, 8'h24);
        rd_chk(CSP_ADDR_PAGE0, 8'h24);
        $display("test loss done");
        @(posedge clk) hr <= 1'b1;
        @(posedge clk) hr <= 1'b0;
        #1 chk(halt_state, 8'h01);
        wr_reg(CSP_ADDR_PAGE0, 8'h00);
        rd_chk(CSP_ADDR_PAGE0, 8'h24);
        @(posedge clk) vd <= 1'b1;
        wait_hi(2, 20);
        chk(voltage_drop_irq, 1'b1);
        rd_chk(CSP_ADDR_PAGE0, 8'h64);
        vd <= 1'b0;
        repeat (3) @(posedge clk);
        srst <= 1'b1;
        @(posedge clk) srst <= 1'b0;
        rd_chk(CSP_ADDR_PAGE0, 8'h00);
        $display("test halt done");
        wr_reg(CSP_ADDR_PAGE0, 8'h80);
        in_circuit_programming <= 1'b1;
        rd_chk(CSP_ADDR_PAGE1, 8'haa);
        osel <= 1'b1;
        wr_reg(CSP_ADDR_PAGE1, 8'h88);
        #1 chk(sysclk_is_pll, 1'b1);
        wr_reg(CSP_ADDR_PAGE0, 8'h20);
        msk <= 1'b1;
        vd <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk(voltage_drop_irq, 1'b0);
        msk <= 1'b0;
        @(posedge clk);
        #1 chk(voltage_drop_irq, 1'b1);
        vd <= 1'b0;
        $display("test option done");
        close_out();
    end
endmodule
`default_nettype wire
